// *** dpc_pkg.sv ***
// Shared constants, timing counts and types for the dual-port memory port host
package dpc_pkg;

    // ------------------------------------------------------------
    // Widths and array shape
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;
    localparam int NUM_BANKS = 2;
    localparam int BANK_W = 1;
    localparam int TOKEN_ADDR_W = 3;
    localparam int TOKEN_BIT = 0;
    localparam int CNT_W = 5;
    localparam int SYNC_W = 2 * NUM_BANKS + DATA_W;

    // ------------------------------------------------------------
    // Timing in nanoseconds and derived cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int BUSY_SETTLE_NS = 45;
    localparam int WRITE_PULSE_NS = 20;
    localparam int READ_ACCESS_NS = 60;
    localparam int RECOVERY_NS = 8;
    localparam int SYNC_LAT_CYC = 3;

    // Least time to whole cycles, never below one
    function automatic int dpc_ns_to_cyc(input int ns);
        int cyc;
        cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    localparam logic [CNT_W-1:0] SETTLE_CYC =
        CNT_W'(dpc_ns_to_cyc(BUSY_SETTLE_NS) + SYNC_LAT_CYC);
    localparam logic [CNT_W-1:0] WRITE_CYC = CNT_W'(dpc_ns_to_cyc(WRITE_PULSE_NS));
    localparam logic [CNT_W-1:0] READ_CYC =
        CNT_W'(dpc_ns_to_cyc(READ_ACCESS_NS) + SYNC_LAT_CYC);
    localparam logic [CNT_W-1:0] RECOVER_CYC = CNT_W'(dpc_ns_to_cyc(RECOVERY_NS));
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [SYNC_W-1:0] SYNC_RESET = {{(2 * NUM_BANKS){1'b1}}, {DATA_W{1'b0}}};
    localparam logic [NUM_BANKS-1:0] SEL_IDLE = {NUM_BANKS{1'b1}};

    // Access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_WAIT_FREE,
        ST_STROBE,
        ST_READ,
        ST_RECOVER
    } dpc_state_t;

endpackage

// *** dpc_sync_if.sv ***
// Raw pin samples and their synchronised copies between host and synchroniser
`timescale 1ns/100ps
interface dpc_sync_if;
    import dpc_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] clean;
    modport host (output raw, input clean);
    modport sync (input raw, output clean);
endinterface

// *** dpc_pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module dpc_pin_sync (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    dpc_sync_if.sync port_if
);
    import dpc_pkg::*;

    logic [SYNC_W-1:0] stage1_reg;
    logic [SYNC_W-1:0] stage2_reg;
    logic [SYNC_W-1:0] stage3_reg;
    logic [SYNC_W-1:0] clean_reg;

    // Shift chain; stage one feeds only stage two
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1_reg <= SYNC_RESET;
            stage2_reg <= SYNC_RESET;
            stage3_reg <= SYNC_RESET;
        end else begin
            stage1_reg <= port_if.raw;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Per bit, take the new level only when the last two stages agree
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clean_reg <= SYNC_RESET;
        end else begin
            clean_reg <= (stage2_reg & stage3_reg) | (clean_reg & (stage2_reg ^ stage3_reg));
        end
    end

    assign port_if.clean = clean_reg;

endmodule // dpc_pin_sync

// *** dpc_port_host.sv ***
// Left-port host controller for a banked dual-port static memory array
`timescale 1ns/100ps
module dpc_port_host (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic req_write_in,
    input wire logic req_token_in,
    input wire logic [dpc_pkg::BANK_W-1:0] req_bank_in,
    input wire logic [dpc_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [dpc_pkg::DATA_W-1:0] req_wdata_in,
    output logic resp_valid_out,
    output logic [dpc_pkg::DATA_W-1:0] resp_rdata_out,
    output logic resp_stalled_out,
    input wire logic slave_role_in,
    input wire logic write_block_in,
    output logic [dpc_pkg::ADDR_W-1:0] mem_addr_out,
    output logic [dpc_pkg::NUM_BANKS-1:0] left_port_select_n_out,
    output logic [dpc_pkg::NUM_BANKS-1:0] token_space_select_n_out,
    output logic rw_n_out,
    output logic oe_n_out,
    input wire logic [dpc_pkg::DATA_W-1:0] data_in,
    output logic [dpc_pkg::DATA_W-1:0] data_out,
    output logic data_oe_out,
    output logic [dpc_pkg::NUM_BANKS-1:0] role_select_out,
    input wire logic [dpc_pkg::NUM_BANKS-1:0] left_collision_flag_n_in,
    output logic [dpc_pkg::NUM_BANKS-1:0] left_collision_flag_n_out,
    output logic [dpc_pkg::NUM_BANKS-1:0] left_collision_flag_n_oe_out,
    input wire logic [dpc_pkg::NUM_BANKS-1:0] right_collision_flag_n_in,
    output logic collision_event_out
);
    import dpc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dpc_state_t state_reg;
    dpc_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic write_reg;
    logic token_reg;
    logic [BANK_W-1:0] bank_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic resp_valid_reg;
    logic stalled_reg;
    logic slave_role_reg;
    logic write_block_reg;
    logic event_reg;
    logic [NUM_BANKS-1:0] sel_n_reg;
    logic [NUM_BANKS-1:0] tok_n_reg;
    logic rw_n_reg;
    logic oe_n_reg;
    logic data_oe_reg;
    logic [NUM_BANKS-1:0] left_busy_n;
    logic [NUM_BANKS-1:0] right_busy_n;
    logic [DATA_W-1:0] rdata_sync;
    logic array_busy_n;
    logic far_busy_n;
    logic pins_active;
    logic [CNT_W-1:0] settled_reg;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    dpc_sync_if sync_bus ();

    assign sync_bus.raw = {right_collision_flag_n_in, left_collision_flag_n_in, data_in};

    dpc_pin_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .port_if(sync_bus.sync)
    );

    assign rdata_sync = sync_bus.clean[DATA_W-1:0];
    assign left_busy_n = sync_bus.clean[DATA_W +: NUM_BANKS];
    assign right_busy_n = sync_bus.clean[DATA_W + NUM_BANKS +: NUM_BANKS];

    assign array_busy_n = &left_busy_n;
    assign far_busy_n = &right_busy_n;

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------

    // Next state and phase counter
    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg == CNT_ZERO) ? CNT_ZERO : cnt_reg - CNT_ONE;
        case (state_reg)
            ST_IDLE: begin
                if (req_valid_in) begin
                    state_next = req_write_in ? ST_SETUP : ST_READ;
                    cnt_next = req_write_in ? SETTLE_CYC - CNT_ONE : READ_CYC - CNT_ONE;
                end
            end
            ST_SETUP: begin
                if (cnt_reg == CNT_ZERO) begin
                    if (slave_role_reg || token_reg || array_busy_n) begin
                        state_next = ST_STROBE;
                        cnt_next = WRITE_CYC - CNT_ONE;
                    end else begin
                        state_next = ST_WAIT_FREE;
                    end
                end
            end
            ST_WAIT_FREE: begin
                if (array_busy_n) begin
                    state_next = ST_STROBE;
                    cnt_next = WRITE_CYC - CNT_ONE;
                end
            end
            ST_STROBE: begin
                if (cnt_reg == CNT_ZERO) begin
                    state_next = ST_RECOVER;
                    cnt_next = RECOVER_CYC - CNT_ONE;
                end
            end
            ST_READ: begin
                if (cnt_reg == CNT_ZERO) begin
                    state_next = ST_RECOVER;
                    cnt_next = RECOVER_CYC - CNT_ONE;
                end
            end
            ST_RECOVER: begin
                if (cnt_reg == CNT_ZERO) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next = CNT_ZERO;
            end
        endcase
    end

    // State and counter registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_IDLE;
            cnt_reg <= CNT_ZERO;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    assign req_ready_out = (state_reg == ST_IDLE);

    // Request capture; address stays frozen for the whole access
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_reg <= 1'b0;
            token_reg <= 1'b0;
            bank_reg <= '0;
            addr_reg <= '0;
            wdata_reg <= '0;
        end else if (state_reg == ST_IDLE && req_valid_in) begin
            write_reg <= req_write_in;
            token_reg <= req_token_in;
            bank_reg <= req_bank_in;
            addr_reg <= req_token_in ? {{(ADDR_W - TOKEN_ADDR_W){1'b0}},
                                        req_addr_in[TOKEN_ADDR_W-1:0]} : req_addr_in;
            wdata_reg <= req_wdata_in;
        end
    end

    // ------------------------------------------------------------
    // Memory port pins
    // ------------------------------------------------------------
    assign pins_active = (state_next != ST_IDLE) && (state_next != ST_RECOVER);

    // Selects, strobe, output enable and data drive follow the next state
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_n_reg <= SEL_IDLE;
            tok_n_reg <= SEL_IDLE;
            rw_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            data_oe_reg <= 1'b0;
        end else begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                sel_n_reg[b] <= !(pins_active && !token_reg && bank_reg == BANK_W'(b));
                tok_n_reg[b] <= !(pins_active && token_reg && bank_reg == BANK_W'(b));
            end
            rw_n_reg <= (state_next != ST_STROBE);
            oe_n_reg <= (state_next != ST_READ);
            data_oe_reg <= pins_active && write_reg;
        end
    end

    assign mem_addr_out = addr_reg;
    assign left_port_select_n_out = sel_n_reg;
    assign token_space_select_n_out = tok_n_reg;
    assign rw_n_out = rw_n_reg;
    assign oe_n_out = oe_n_reg;
    assign data_out = wdata_reg;
    assign data_oe_out = data_oe_reg;

    // ------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------

    // Read capture, completion pulse and stall report
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_reg <= '0;
            resp_valid_reg <= 1'b0;
            stalled_reg <= 1'b0;
        end else begin
            resp_valid_reg <= (state_next == ST_RECOVER) && (state_reg != ST_RECOVER);
            if (state_reg == ST_READ && cnt_reg == CNT_ZERO) begin
                rdata_reg <= token_reg ? {DATA_W{rdata_sync[TOKEN_BIT]}} : rdata_sync;
            end
            if (state_reg == ST_IDLE && req_valid_in) begin
                stalled_reg <= 1'b0;
            end else if (state_reg == ST_WAIT_FREE) begin
                stalled_reg <= 1'b1;
            end
        end
    end

    assign resp_valid_out = resp_valid_reg;
    assign resp_rdata_out = rdata_reg;
    assign resp_stalled_out = stalled_reg;

    // ------------------------------------------------------------
    // Role and collision flag pins
    // ------------------------------------------------------------

    // slave flags held high, or low to block
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slave_role_reg <= 1'b0;
            write_block_reg <= 1'b0;
        end else begin
            slave_role_reg <= slave_role_in;
            write_block_reg <= write_block_in;
        end
    end

    assign role_select_out = {NUM_BANKS{!slave_role_reg}};
    assign left_collision_flag_n_out = {NUM_BANKS{!write_block_reg}};
    assign left_collision_flag_n_oe_out = {NUM_BANKS{slave_role_reg}};

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            event_reg <= 1'b0;
        end else begin
            event_reg <= !slave_role_reg && (!array_busy_n || !far_busy_n);
        end
    end

    assign collision_event_out = event_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Cycles the selects have stood active
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settled_reg <= CNT_ZERO;
        end else if (&sel_n_reg && &tok_n_reg) begin
            settled_reg <= CNT_ZERO;
        end else if (settled_reg != 5'h1f) begin
            settled_reg <= settled_reg + CNT_ONE;
        end
    end

    sequence strobe_start_s;
        $fell(rw_n_out);
    endsequence

    sequence master_data_write_s;
        !slave_role_reg && !token_reg ##0 strobe_start_s;
    endsequence

    strobe_settle_a: assert property (strobe_start_s |-> settled_reg >= SETTLE_CYC)
        else $error("write strobe began before the collision flag settled");

    addr_hold_a: assert property (!rw_n_out |-> ##1 $stable(mem_addr_out)
        && ($stable(left_port_select_n_out) || $past(rw_n_out) != rw_n_out || rw_n_out))
        else $error("address or select moved during write strobe");

    busy_gate_a: assert property (master_data_write_s |-> $past(array_busy_n))
        else $error("write strobe started while a bank flagged collision");

    slave_drive_a: assert property ($rose(slave_role_in) |-> ##1
        (&left_collision_flag_n_oe_out) [*2])
        else $error("slave role flag pins not driven");

    role_pins_a: assert property (slave_role_in |=> role_select_out == '0)
        else $error("role pins not set to slave");

    // Raw flag low for five samples must reach the event through the synchroniser
    event_or_a: assert property ((!slave_role_reg && (!(&left_collision_flag_n_in)
        || !(&right_collision_flag_n_in))) [*5] |=> collision_event_out)
        else $error("collision event missed");

endmodule // dpc_port_host

// *** dpc_mem_model.sv ***
// Behavioural model of the two banked dual-port memories as seen from the left port
`timescale 1ns/100ps
module dpc_mem_model (
    input wire logic sys_clk_in,
    input wire logic [dpc_pkg::ADDR_W-1:0] addr_in,
    input wire logic [dpc_pkg::NUM_BANKS-1:0] sel_n_in,
    input wire logic [dpc_pkg::NUM_BANKS-1:0] tok_n_in,
    input wire logic rw_n_in,
    input wire logic oe_n_in,
    input wire logic [dpc_pkg::DATA_W-1:0] wdata_in,
    input wire logic wdata_oe_in,
    input wire logic [dpc_pkg::NUM_BANKS-1:0] role_in,
    input wire logic [dpc_pkg::NUM_BANKS-1:0] host_flag_n_in,
    input wire logic [dpc_pkg::NUM_BANKS-1:0] host_flag_oe_in,
    input wire logic [dpc_pkg::NUM_BANKS-1:0] right_hit_in,
    input wire logic right_hold_in,
    output logic [dpc_pkg::DATA_W-1:0] rdata_out,
    output logic [dpc_pkg::NUM_BANKS-1:0] left_flag_n_out,
    output logic [dpc_pkg::NUM_BANKS-1:0] right_flag_n_out
);
    import dpc_pkg::*;
    logic [DATA_W-1:0] mem_q [NUM_BANKS][2**ADDR_W];
    logic [7:0] left_own [NUM_BANKS];
    logic [7:0] left_pend [NUM_BANKS];
    logic right_own = 1'b0;
    logic tok_latch = 1'b1;
    logic tok_reading = 1'b0;
    logic idle_tick = 1'b0;
    logic bk;
    logic tok_rd;
    logic busy_r;
    logic [NUM_BANKS-1:0] dev_flag_n;
    logic [NUM_BANKS-1:0] write_ok;
    // Bank picked by whichever select is low
    assign bk = ~(sel_n_in[1] & tok_n_in[1]);
    assign tok_rd = ~oe_n_in & ~tok_n_in[bk];
    assign busy_r = (bk == 1'b0 && addr_in[2:0] == 3'h0) ? right_own : 1'b0;
    // Right port settled first, so left is flagged
    assign dev_flag_n = ~(role_in & ~sel_n_in & right_hit_in);
    assign right_flag_n_out = {NUM_BANKS{1'b1}};
    // Slave pins follow the host, or toggle when nobody drives them
    assign left_flag_n_out = (role_in & dev_flag_n) |
        (~role_in & host_flag_oe_in & host_flag_n_in) |
        (~role_in & ~host_flag_oe_in & {NUM_BANKS{idle_tick}});
    // Internal write inhibit in master, pin inhibit in slave
    assign write_ok = (role_in & dev_flag_n) | (~role_in & left_flag_n_out);
    // Data only while selected, else a changing pattern
    always_comb begin
        if (!oe_n_in && !sel_n_in[bk]) begin
            rdata_out = mem_q[bk][addr_in];
        end else if (tok_rd) begin
            rdata_out = {DATA_W{tok_reading ? tok_latch : ~left_own[bk][addr_in[2:0]]}};
        end else begin
            rdata_out = {(DATA_W / 2){idle_tick, ~idle_tick}};
        end
    end
    // Token latches start free
    initial begin
        left_own = '{8'h00, 8'h00};
        left_pend = '{8'h00, 8'h00};
    end
    // Writes, token latches and the right side's claim
    always @(posedge sys_clk_in) begin
        idle_tick <= ~idle_tick;
        tok_reading <= tok_rd;
        if (tok_rd && !tok_reading) begin
            tok_latch <= ~left_own[bk][addr_in[2:0]];
        end
        if (!rw_n_in && wdata_oe_in) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                if (!sel_n_in[b] && write_ok[b]) begin
                    mem_q[b][addr_in] <= wdata_in;
                end
            end
            if (!tok_n_in[bk] && !wdata_in[TOKEN_BIT] && !busy_r) begin
                left_own[bk][addr_in[2:0]] <= 1'b1;
            end else if (!tok_n_in[bk] && !wdata_in[TOKEN_BIT]) begin
                left_pend[bk][addr_in[2:0]] <= 1'b1;
            end else if (!tok_n_in[bk]) begin
                left_own[bk][addr_in[2:0]] <= 1'b0;
                left_pend[bk][addr_in[2:0]] <= 1'b0;
            end
        end
        if (right_hold_in && !right_own && !left_own[0][0]) begin
            right_own <= 1'b1;
        end else if (!right_hold_in && right_own) begin
            right_own <= 1'b0;
            left_own[0][0] <= left_pend[0][0];
            left_pend[0][0] <= 1'b0;
        end
    end
endmodule // dpc_mem_model

// *** dpc_port_host_tb_top.sv ***
// Self-checking testbench for the left-port host controller
`timescale 1ns/100ps
module dpc_port_host_tb_top;
    import dpc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, req_token = 1'b0, req_bank = 1'b0;
    logic [ADDR_W-1:0] req_addr = 14'h0000;
    logic [DATA_W-1:0] req_wdata = 16'h0000;
    logic slave_role = 1'b0, write_block = 1'b0, right_hold = 1'b0;
    logic [NUM_BANKS-1:0] right_hit = 2'h0;
    logic req_ready, resp_valid, resp_stalled, rw_n, oe_n, data_oe, coll_event;
    logic [DATA_W-1:0] resp_rdata, pin_rdata, pin_wdata;
    logic [ADDR_W-1:0] mem_addr;
    logic [NUM_BANKS-1:0] sel_n, tok_n, role_sel, lflag, lflag_out, lflag_oe, rflag;
    logic [DATA_W-1:0] rd;
    int n;
    int fail_count = 0;
    int check_count = 0;
    always #2 sys_clk = ~sys_clk;
    dpc_port_host dut_u (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .req_valid_in(req_valid),
        .req_ready_out(req_ready), .req_write_in(req_write), .req_token_in(req_token),
        .req_bank_in(req_bank), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
        .resp_valid_out(resp_valid), .resp_rdata_out(resp_rdata),
        .resp_stalled_out(resp_stalled), .slave_role_in(slave_role),
        .write_block_in(write_block), .mem_addr_out(mem_addr),
        .left_port_select_n_out(sel_n), .token_space_select_n_out(tok_n), .rw_n_out(rw_n),
        .oe_n_out(oe_n), .data_in(pin_rdata), .data_out(pin_wdata), .data_oe_out(data_oe),
        .role_select_out(role_sel), .left_collision_flag_n_in(lflag),
        .left_collision_flag_n_out(lflag_out), .left_collision_flag_n_oe_out(lflag_oe),
        .right_collision_flag_n_in(rflag), .collision_event_out(coll_event));
    dpc_mem_model mem_u (.sys_clk_in(sys_clk), .addr_in(mem_addr), .sel_n_in(sel_n),
        .tok_n_in(tok_n), .rw_n_in(rw_n), .oe_n_in(oe_n), .wdata_in(pin_wdata),
        .wdata_oe_in(data_oe), .role_in(role_sel), .host_flag_n_in(lflag_out),
        .host_flag_oe_in(lflag_oe), .right_hit_in(right_hit), .right_hold_in(right_hold),
        .rdata_out(pin_rdata), .left_flag_n_out(lflag), .right_flag_n_out(rflag));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic access(input logic wr, input logic tok, input logic bank,
        input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wd);
        n = 0;
        while (req_ready !== 1'b1) begin
            tick(1);
            n++;
            if (n > 300) begin
                fail_count++;
                results();
            end
        end
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_token <= tok;
        req_bank <= bank;
        req_addr <= addr;
        req_wdata <= wd;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            tick(1);
            n++;
            if (n > 300) begin
                fail_count++;
                results();
            end
        end while (resp_valid !== 1'b1);
        rd = resp_rdata;
        tick(1);
        check(resp_valid, 1'b0);
        check(req_ready, 1'b0);
        tick(1);
        check(req_ready, 1'b1);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(sel_n & tok_n, 2'h3);
        check(role_sel, 2'h3);
        check({lflag_oe, coll_event, rw_n, oe_n, data_oe}, 7'h06);
        $display("test reset done");
    endtask
    task automatic t_rw();
        access(1'b1, 1'b0, 1'b0, 14'h0000, 16'h1234);
        check(DATA_W'(n), 16'd20);
        check(resp_stalled, 1'b0);
        access(1'b1, 1'b0, 1'b1, 14'h3fff, 16'hbeef);
        access(1'b0, 1'b0, 1'b0, 14'h0000, 16'h0000);
        check(DATA_W'(n), 16'd18);
        check(rd, 16'h1234);
        access(1'b0, 1'b0, 1'b1, 14'h3fff, 16'h0000);
        check(rd, 16'hbeef);
        $display("test read write done");
    endtask
    task automatic t_stall();
        right_hit <= 2'h1;
        fork
            access(1'b1, 1'b0, 1'b0, 14'h0100, 16'h5a5a);
            begin
                tick(40);
                check(coll_event, 1'b1);
                check(resp_valid, 1'b0);
                @(posedge sys_clk);
                right_hit <= 2'h0;
            end
        join
        check(DATA_W'(n > 21), 16'h0001);
        check(resp_stalled, 1'b1);
        check(coll_event, 1'b0);
        access(1'b0, 1'b0, 1'b0, 14'h0100, 16'h0000);
        check(rd, 16'h5a5a);
        $display("test collision stall done");
    endtask
    task automatic t_slave();
        @(posedge sys_clk);
        slave_role <= 1'b1;
        tick(6);
        check({role_sel, lflag_oe, lflag_out}, 6'h0f);
        access(1'b1, 1'b0, 1'b0, 14'h0200, 16'h1111);
        check(DATA_W'(n), 16'd20);
        @(posedge sys_clk);
        write_block <= 1'b1;
        tick(6);
        check(lflag_out, 2'h0);
        access(1'b1, 1'b0, 1'b0, 14'h0200, 16'h2222);
        access(1'b0, 1'b0, 1'b0, 14'h0200, 16'h0000);
        check(rd, 16'h1111);
        @(posedge sys_clk);
        slave_role <= 1'b0;
        write_block <= 1'b0;
        tick(6);
        $display("test slave role done");
    endtask
    task automatic t_token();
        access(1'b1, 1'b1, 1'b1, 14'h3ffd, 16'h0000);
        access(1'b0, 1'b1, 1'b1, 14'h0005, 16'h0000);
        check(rd, 16'h0000);
        access(1'b1, 1'b1, 1'b1, 14'h0005, 16'h0001);
        access(1'b0, 1'b1, 1'b1, 14'h0005, 16'h0000);
        check(rd, 16'hffff);
        right_hold <= 1'b1;
        tick(2);
        access(1'b1, 1'b1, 1'b0, 14'h0000, 16'h0000);
        access(1'b0, 1'b1, 1'b0, 14'h0000, 16'h0000);
        check(rd, 16'hffff);
        right_hold <= 1'b0;
        tick(2);
        access(1'b0, 1'b1, 1'b0, 14'h0000, 16'h0000);
        check(rd, 16'h0000);
        access(1'b1, 1'b1, 1'b0, 14'h0000, 16'h0001);
        access(1'b0, 1'b0, 1'b1, 14'h3fff, 16'h0000);
        check(rd, 16'hbeef);
        $display("test token done");
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(1);
        t_reset();
        t_rw();
        t_stall();
        t_slave();
        t_token();
        results();
    end
endmodule // dpc_port_host_tb_top
